// ---- logic/fmt_cfg_regs.svh ----
/*
  Holds the register offset, field positions, reset value and timing
  counts of the channel output format configuration block.
  Assumes a 40 MHz system clock and 16-bit sensor samples.
*/
// What this block does
// R1: One 8-bit configuration register sits at 0x42 with coding, primary, secondary and averaging fields.
// R2: The register can be read and written in DSI3, SPI, I2C and PSI5 programming modes.
// R3: The register is covered by the configuration array check, so any corrupted bit raises an error.
// R4: Coding select 0 gives signed channel data everywhere, 1 gives unsigned results and DSI/SPI data.
// R5: Primary code 00 loads offset-cancelled channel data with averaging and interpolation per window.
// R6: Primary code 01 loads channel data that skipped offset cancellation.
// R7: Primary codes 10 and 11 load temperature data.
// R8: Secondary code 000 loads offset-cancelled data, averaged per window, never interpolated.
// R9: Secondary codes 001 and 101 load uncancelled data, averaged per window, not interpolated.
// R10: Secondary code 100 loads offset-cancelled data with no averaging and no interpolation.
// R11: Secondary codes 010, 011, 110 and 111 load temperature data.
// R12: Window 00 bypasses averaging and enables interpolation for primary codes 00 and 01; 01, 10, 11 average 8 samples at 32, 64, 128 us.
// R13: A write that changes the window resets the data path; results are invalid until it reinitialises.
// R14: After reset every bit of the register reads zero.
`ifndef FMT_CFG_REGS_SVH
`define FMT_CFG_REGS_SVH

`define CFG_ADDR 8'h42
`define CFG_RESET 8'h00
`define CODING_BIT 7
`define PRIM_MSB 6
`define PRIM_LSB 5
`define SEC_MSB 4
`define SEC_LSB 2
`define WIN_MSB 1
`define WIN_LSB 0

`define SAMPLE_W 16
`define AVG_DEPTH 8
`define AVG_SHIFT 3
`define CLK_PERIOD_PS 25000
`define WIN1_PERIOD_US 32
`define WIN2_PERIOD_US 64
`define WIN3_PERIOD_US 128
`define WIN1_CYCLES ((`WIN1_PERIOD_US * 1000000) / `CLK_PERIOD_PS)
`define WIN2_CYCLES ((`WIN2_PERIOD_US * 1000000) / `CLK_PERIOD_PS)
`define WIN3_CYCLES ((`WIN3_PERIOD_US * 1000000) / `CLK_PERIOD_PS)
`define CRC_POLY 8'h2f

`endif

// ---- logic/fmt_cfg_pkg.sv ----
/*
  Types shared by the output format configuration block.
  Assumes the constants header is on the include path.
*/
`include "fmt_cfg_regs.svh"

package fmt_cfg_pkg;

  typedef enum logic [2:0] {
    MODE_DSI3,
    MODE_SPI,
    MODE_I2C,
    MODE_PSI5_PROG,
    MODE_PSI5_RUN
  } host_mode_t;

  typedef struct packed {
    logic magnitude_coding_select;
    logic [1:0] primary_result_select;
    logic [2:0] secondary_result_select;
    logic [1:0] averaging_window_select;
  } cfg_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } result_pair_t;

  typedef enum logic [1:0] {
    DSP_RUN,
    DSP_CLEAR,
    DSP_INIT
  } dsp_state_t;

endpackage

// ---- logic/moving_avg8.sv ----
/*
  Eight-sample sliding average with its own sample history.
  Assumes one-cycle sample strobes and a clear from the owner.
*/
`timescale 1ns/10ps

module moving_avg8
  import fmt_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic sample_valid,
  input wire logic signed [`SAMPLE_W-1:0] sample_in,
  output logic signed [`SAMPLE_W-1:0] avg_out
);

  localparam int SUM_W = `SAMPLE_W + `AVG_SHIFT;

  logic signed [`SAMPLE_W-1:0] hist_q [`AVG_DEPTH];
  logic signed [`SAMPLE_W-1:0] hist_d [`AVG_DEPTH];
  logic [`AVG_SHIFT-1:0] ptr_q, ptr_d;
  logic signed [SUM_W-1:0] sum_q, sum_d;
  logic signed [`SAMPLE_W-1:0] avg_q, avg_d;

  always_comb
  begin
    hist_d = hist_q;
    ptr_d = ptr_q;
    sum_d = sum_q;
    avg_d = sum_q[SUM_W-1:`AVG_SHIFT];
    if (clear)
    begin
      for (int i = 0; i < `AVG_DEPTH; i++)
      begin
        hist_d[i] = '0;
      end
      ptr_d = '0;
      sum_d = '0;
      avg_d = '0;
    end
    else if (sample_valid)
    begin
      // Drop the oldest sample, add the newest
      sum_d = SUM_W'(sum_q - SUM_W'(hist_q[ptr_q]) + SUM_W'(sample_in));
      hist_d[ptr_q] = sample_in;
      ptr_d = ptr_q + 3'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < `AVG_DEPTH; i++)
      begin
        hist_q[i] <= '0;
      end
      ptr_q <= '0;
      sum_q <= '0;
      avg_q <= '0;
    end
    else
    begin
      hist_q <= hist_d;
      ptr_q <= ptr_d;
      sum_q <= sum_d;
      avg_q <= avg_d;
    end
  end

  assign avg_out = avg_q;

endmodule

// ---- logic/cfg_array_check.sv ----
/*
  Check code over the configuration byte: stored on each legal write,
  recomputed every cycle, mismatch raises a sticky error.
  Assumes writes arrive as one-cycle strobes.
*/
`timescale 1ns/10ps

module cfg_array_check
  import fmt_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [7:0] load_data,
  input wire logic [7:0] stored_data,
  output logic error
);

  logic [7:0] code_q, code_d;
  logic err_q, err_d;

  function automatic logic [7:0] crc8(input logic [7:0] data);
    logic [7:0] crc;
    crc = 8'hff;
    for (int i = 7; i >= 0; i--)
    begin
      if (crc[7] ^ data[i])
        crc = {crc[6:0], 1'b0} ^ `CRC_POLY;
      else
        crc = {crc[6:0], 1'b0};
    end
    return crc;
  endfunction

  always_comb
  begin
    code_d = code_q;
    err_d = err_q;
    // R3: corruption sets the flag, a fresh write clears it
    if (load)
    begin
      code_d = crc8(load_data);
      err_d = 1'b0;
    end
    else if (crc8(stored_data) != code_q)
    begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      code_q <= crc8(`CFG_RESET);
      err_q <= 1'b0;
    end
    else
    begin
      code_q <= code_d;
      err_q <= err_d;
    end
  end

  always_comb
  begin
    error = err_q;
    if (rst)
      error = 1'b0;
  end

endmodule

// ---- logic/sensor_output_format_select.sv ----
/*
  Channel output format configuration register and the result
  selection it steers: coding, source choice per result pair,
  sliding average timing and data path reset on window change.
  Assumes all inputs come from logic on MCLK; the offset-cancelled
  sample already follows the offset filter setting upstream.
*/
`timescale 1ns/10ps

module sensor_output_format_select
  import fmt_cfg_pkg::*;
#(
  parameter int WIN3_CYCLES = `WIN3_CYCLES
)
(
  input wire logic MCLK,
  input wire logic RST,
  input wire host_mode_t HOST_MODE,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_ACK,
  input wire logic LPF_SAMPLE_VALID,
  input wire logic signed [`SAMPLE_W-1:0] CANCELLED_DATA,
  input wire logic signed [`SAMPLE_W-1:0] RAW_DATA,
  input wire logic [`SAMPLE_W-1:0] TEMP_DATA,
  output result_pair_t PRIMARY_RESULT,
  output result_pair_t SECONDARY_RESULT,
  output logic RESULT_VALID,
  output logic PRIMARY_INTERP_EN,
  output logic TX_UNSIGNED,
  output logic DSP_RESET,
  output logic ARRAY_ERROR
);

  localparam int CNT_W = 13;

  cfg_t cfg_q, cfg_d;
  logic [7:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic hit, access_ok, wr_ok, rd_ok, win_change;

  dsp_state_t state_q, state_d;
  logic [CNT_W-1:0] tick_q, tick_d;
  logic [`AVG_SHIFT-1:0] init_q, init_d;
  logic sample_strobe, avg_on, clear_avg;

  logic signed [`SAMPLE_W-1:0] canc_avg, raw_avg;
  logic signed [`SAMPLE_W-1:0] canc_f, raw_f;
  logic [`SAMPLE_W-1:0] prim_d, sec_d, prim_q, sec_q;
  logic interp_q, interp_d;
  logic valid_q, valid_d;

  // Input period in clocks per window code
  function automatic logic [CNT_W-1:0] win_cycles(input logic [1:0] sel);
    case (sel)
      2'h1: return CNT_W'(`WIN1_CYCLES);
      2'h2: return CNT_W'(`WIN2_CYCLES);
      default: return CNT_W'(WIN3_CYCLES);
    endcase
  endfunction

  // Result coding shared by both pairs
  function automatic logic [`SAMPLE_W-1:0] code_chan(
    input logic [`SAMPLE_W-1:0] x,
    input logic unsigned_sel
  );
    // Offset binary: flip the sign bit
    if (unsigned_sel)
      return {~x[`SAMPLE_W-1], x[`SAMPLE_W-2:0]};
    else
      return x;
  endfunction

  // R2: access in every mode except running PSI5
  always_comb
  begin
    access_ok = (HOST_MODE != MODE_PSI5_RUN);
  end

  // R1: single register decode at its address
  always_comb
  begin
    hit = (REG_ADDR == `CFG_ADDR);
    wr_ok = REG_WR && hit && access_ok;
    rd_ok = REG_RD && hit && access_ok;
  end

  // R13: window change on a legal write
  always_comb
  begin
    win_change = wr_ok &&
      (REG_WDATA[`WIN_MSB:`WIN_LSB] != cfg_q.averaging_window_select);
  end

  always_comb
  begin
    cfg_d = cfg_q;
    rdata_d = 8'h00;
    ack_d = 1'b0;
    if (wr_ok)
    begin
      // R1: field layout of the write
      cfg_d.magnitude_coding_select = REG_WDATA[`CODING_BIT];
      cfg_d.primary_result_select = REG_WDATA[`PRIM_MSB:`PRIM_LSB];
      cfg_d.secondary_result_select = REG_WDATA[`SEC_MSB:`SEC_LSB];
      cfg_d.averaging_window_select = REG_WDATA[`WIN_MSB:`WIN_LSB];
      ack_d = 1'b1;
    end
    else if (rd_ok)
    begin
      rdata_d = cfg_q;
      ack_d = 1'b1;
    end
  end

  // One-byte register file
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      // R14: all zero after reset
      cfg_q <= `CFG_RESET;
      rdata_q <= 8'h00;
      ack_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  assign REG_RDATA = rdata_q;
  assign REG_ACK = ack_q;

  // R3: register covered by the array check
  cfg_array_check u_check (
    .clk(MCLK),
    .rst(RST),
    .load(wr_ok),
    .load_data(REG_WDATA),
    .stored_data(cfg_q),
    .error(ARRAY_ERROR)
  );

  // R12: averaging input period from the window field
  always_comb
  begin
    avg_on = (cfg_q.averaging_window_select != 2'h0);
    if (avg_on)
      sample_strobe = (tick_q == win_cycles(cfg_q.averaging_window_select)
        - CNT_W'(1));
    else
      sample_strobe = LPF_SAMPLE_VALID;
  end

  always_comb
  begin
    state_d = state_q;
    tick_d = tick_q;
    init_d = init_q;
    // Input period counter
    if (!avg_on || sample_strobe)
      tick_d = '0;
    else
      tick_d = tick_q + CNT_W'(1);
    case (state_q)
      DSP_RUN:
      begin
        if (win_change)
          state_d = DSP_CLEAR;
      end
      DSP_CLEAR:
      begin
        // Averagers empty now; a write here never sends INIT back to CLEAR
        tick_d = '0;
        init_d = '0;
        state_d = DSP_INIT;
      end
      DSP_INIT:
      begin
        // R13: refill the history before results count
        if (win_change)
          state_d = DSP_CLEAR;
        else if (sample_strobe)
        begin
          init_d = init_q + 3'h1;
          if (init_q == 3'h7)
            state_d = DSP_RUN;
        end
      end
      default:
        state_d = DSP_RUN;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      state_q <= DSP_RUN;
      tick_q <= '0;
      init_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      tick_q <= tick_d;
      init_q <= init_d;
    end
  end

  // R13: data path reset pulse
  assign clear_avg = (state_q == DSP_CLEAR);
  assign DSP_RESET = clear_avg;

  moving_avg8 u_avg_canc (
    .clk(MCLK),
    .rst(RST),
    .clear(clear_avg),
    .sample_valid(sample_strobe),
    .sample_in(CANCELLED_DATA),
    .avg_out(canc_avg)
  );

  moving_avg8 u_avg_raw (
    .clk(MCLK),
    .rst(RST),
    .clear(clear_avg),
    .sample_valid(sample_strobe),
    .sample_in(RAW_DATA),
    .avg_out(raw_avg)
  );

  // R12: averaged or direct per window
  always_comb
  begin
    canc_f = avg_on ? canc_avg : CANCELLED_DATA;
    raw_f = avg_on ? raw_avg : RAW_DATA;
  end

  always_comb
  begin
    // Temperature words are never recoded
    // R7: temperature on upper primary bit
    if (cfg_q.primary_result_select[1])
      prim_d = TEMP_DATA;
    // R6: uncancelled channel data
    else if (cfg_q.primary_result_select[0])
      prim_d = code_chan(raw_f, cfg_q.magnitude_coding_select);
    // R5: cancelled and averaged per window
    else
      prim_d = code_chan(canc_f, cfg_q.magnitude_coding_select);
    case (cfg_q.secondary_result_select)
      // R8: cancelled, averaged per window
      3'h0: sec_d = code_chan(canc_f, cfg_q.magnitude_coding_select);
      // R9: uncancelled, averaged per window
      3'h1, 3'h5: sec_d = code_chan(raw_f, cfg_q.magnitude_coding_select);
      // R10: cancelled, never averaged
      3'h4: sec_d = code_chan(CANCELLED_DATA,
        cfg_q.magnitude_coding_select);
      // R11: temperature for the remaining codes
      default: sec_d = TEMP_DATA;
    endcase
    // R12: interpolation only when averaging is bypassed
    interp_d = !avg_on && !cfg_q.primary_result_select[1];
    // R13: valid drops the cycle a changing write lands
    valid_d = (state_q == DSP_RUN) && !win_change;
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      // Both pairs update together
      prim_q <= '0;
      sec_q <= '0;
      interp_q <= 1'b0;
      valid_q <= 1'b0;
    end
    else
    begin
      prim_q <= prim_d;
      sec_q <= sec_d;
      interp_q <= interp_d;
      valid_q <= valid_d;
    end
  end

  // R4: unsigned coding reaches DSI and SPI, never PSI5
  assign TX_UNSIGNED = cfg_q.magnitude_coding_select &&
    (HOST_MODE != MODE_PSI5_PROG) && (HOST_MODE != MODE_PSI5_RUN);

  assign PRIMARY_RESULT = prim_q;
  assign SECONDARY_RESULT = sec_q;
  assign PRIMARY_INTERP_EN = interp_q;
  assign RESULT_VALID = valid_q;

endmodule

// ---- verif/fmt_sel_monitor.sv ----
/*
  Port checker for the output format select block.
  Assumes it is bound into the top module, one clock MCLK.
*/
`timescale 1ns/10ps

module fmt_sel_monitor
  import fmt_cfg_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire host_mode_t HOST_MODE,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_ACK,
  input wire logic signed [15:0] CANCELLED_DATA,
  input wire logic [15:0] TEMP_DATA,
  input wire result_pair_t PRIMARY_RESULT,
  input wire result_pair_t SECONDARY_RESULT,
  input wire logic RESULT_VALID,
  input wire logic PRIMARY_INTERP_EN,
  input wire logic TX_UNSIGNED,
  input wire logic DSP_RESET
);
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic hit;
  logic wr;
  assign hit = REG_ADDR == 8'h42 && HOST_MODE != MODE_PSI5_RUN;
  assign wr = hit && REG_WR;
  always_comb sh_d = RST ? 8'h00 : (wr ? REG_WDATA : sh_q);
  always_ff @(posedge MCLK) sh_q <= sh_d;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);

  a_ack_taken: assert property (hit && (REG_WR || REG_RD)
    |=> REG_ACK) else $error("ack missing");
  a_ack_refused: assert property (!(hit && (REG_WR || REG_RD))
    |=> !REG_ACK) else $error("stray ack");
  a_rdata_idle: assert property (!REG_ACK
    |-> REG_RDATA == 8'h00) else $error("read data not idle");
  a_read_value: assert property (hit && REG_RD && !REG_WR
    |=> REG_RDATA == $past(sh_q)) else $error("bad read data");
  a_dsp_pulse: assert property (DSP_RESET
    |-> !RESULT_VALID ##1 !DSP_RESET) else $error("bad clear pulse");
  a_win_reset: assert property (wr && REG_WDATA[1:0] != sh_q[1:0]
    |-> ##[1:2] DSP_RESET) else $error("no clear on window");
  a_psi5_signed: assert property (HOST_MODE >= MODE_PSI5_PROG
    |-> !TX_UNSIGNED) else $error("unsigned in psi5");
  a_prim_temp: assert property (sh_q[6] && !wr
    |=> PRIMARY_RESULT == $past(TEMP_DATA)) else $error("primary temp");
  a_sec_temp: assert property (sh_q[3] && !wr
    |=> SECONDARY_RESULT == $past(TEMP_DATA)) else $error("second temp");
  a_sec_plain: assert property (
    sh_q[4:2] == 3'b100 && !wr && RESULT_VALID
    |=> SECONDARY_RESULT ==
    ($past(CANCELLED_DATA) ^ {sh_q[7], 15'h0000})) else $error("second");
  a_interp_flag: assert property (
    sh_q[1:0] == 2'b00 && !sh_q[6] && !wr
    |=> PRIMARY_INTERP_EN) else $error("interp flag low");
endmodule

bind sensor_output_format_select fmt_sel_monitor i_fmt_sel_monitor (
  .MCLK(MCLK), .RST(RST), .HOST_MODE(HOST_MODE), .REG_ADDR(REG_ADDR),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK),
  .CANCELLED_DATA(CANCELLED_DATA), .TEMP_DATA(TEMP_DATA),
  .PRIMARY_RESULT(PRIMARY_RESULT), .SECONDARY_RESULT(SECONDARY_RESULT),
  .RESULT_VALID(RESULT_VALID), .PRIMARY_INTERP_EN(PRIMARY_INTERP_EN),
  .TX_UNSIGNED(TX_UNSIGNED), .DSP_RESET(DSP_RESET)
);

// ---- verif/tb.sv ----
/*
  Self-checking bench for the output format select block.
  Assumes package, header and design are compiled first.
*/
`timescale 1ns/10ps

module tb
  import fmt_cfg_pkg::*;
;
  int num_errors = 0;
  int cmp_count = 0;
  int seed = 32'hf65feadd;
  int cfg = 0;
  logic mclk = 0;
  logic rst = 1;
  host_mode_t mode = MODE_DSI3;
  logic [7:0] addr = 8'h00;
  logic wr = 0;
  logic rd = 0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic ack;
  logic lpf = 0;
  logic signed [15:0] canc = 16'sh0000;
  logic signed [15:0] raw = 16'sh0000;
  logic [15:0] temp = 16'h0000;
  result_pair_t prim;
  result_pair_t sec;
  logic valid;
  logic interp;
  logic txu;
  logic aerr;

  sensor_output_format_select #(.WIN3_CYCLES(40))
    i_sensor_output_format_select (
    .MCLK(mclk), .RST(rst), .HOST_MODE(mode), .REG_ADDR(addr),
    .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .REG_ACK(ack), .LPF_SAMPLE_VALID(lpf), .CANCELLED_DATA(canc),
    .RAW_DATA(raw), .TEMP_DATA(temp), .PRIMARY_RESULT(prim),
    .SECONDARY_RESULT(sec), .RESULT_VALID(valid),
    .PRIMARY_INTERP_EN(interp), .TX_UNSIGNED(txu), .DSP_RESET(),
    .ARRAY_ERROR(aerr)
  );

  initial forever #12.5 mclk = ~mclk;
  // Sample pace for window 00, one-cycle pulses
  always @(negedge mclk) lpf <= !lpf && !rst;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] d, input logic ok);
    @(negedge mclk);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(negedge mclk);
    wr = 0;
    rd = 0;
    chk(ack, ok);
    if (ok && w)
      cfg = d;
    if (!w)
      chk(rdata, ok ? cfg[7:0] : 8'h00);
  endtask

  // Model of both result pairs for inputs held steady
  task automatic res_chk();
    logic [15:0] u;
    logic [15:0] p;
    logic [15:0] s;
    u = {cfg[7], 15'h0000};
    p = cfg[6] ? temp : ((cfg[5] ? raw : canc) ^ u);
    s = cfg[3] ? temp : (((cfg[4:2] == 1 || cfg[4:2] == 5) ? raw : canc) ^ u);
    chk(prim, p);
    chk(sec, s);
    chk(interp, cfg[1:0] == 0 && !cfg[6]);
    chk(txu, cfg[7] && mode < MODE_PSI5_PROG);
  endtask

  task automatic wait_valid();
    int n;
    n = 0;
    while (valid !== 1'b1 && n < 1000)
    begin
      @(negedge mclk);
      n++;
    end
    chk(n < 1000, 1);
    repeat (4) @(negedge mclk);
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #1000000;
    num_errors++;
    final_report();
  end

  initial
  begin
    repeat (10) @(negedge mclk);
    rst = 0;
    wait_valid();
    acc(0, 8'h42, 8'h00, 1);
    chk(aerr, 0);
    $display("reset test done");
    for (int m = 0; m < 5; m++)
    begin
      mode = host_mode_t'(m);
      acc(1, 8'h42, 8'($random(seed)) & 8'hfc, m < 4);
      acc(0, 8'h42, 8'h00, m < 4);
    end
    mode = MODE_I2C;
    acc(1, 8'h43, 8'h55, 0);
    acc(0, 8'h43, 8'h00, 0);
    $display("access test done");
    for (int c = 0; c < 256; c += 4)
    begin
      mode = host_mode_t'((c >> 2) % 4);
      acc(1, 8'h42, 8'(c), 1);
      canc = 16'($random(seed));
      raw = 16'($random(seed));
      temp = 16'($random(seed));
      @(negedge mclk);
      res_chk();
    end
    $display("select test done");
    mode = MODE_SPI;
    acc(1, 8'h42, 8'h83, 1);
    @(negedge mclk);
    chk(valid, 0);
    wait_valid();
    res_chk();
    acc(1, 8'h42, 8'h00, 1);
    @(negedge mclk);
    chk(valid, 0);
    wait_valid();
    res_chk();
    chk(aerr, 0);
    $display("window test done");
    final_report();
  end
endmodule
